// file: logic/scg_pkg.sv
/*
 * Constants and types for the self-calibration gain block.
 * Assumes the command framing outside marks the start of each
 * coefficient transfer and hands over one bit per strobe.
 */
package scg_pkg;
	// ----------------------------------------------------------------
	// Coefficient format
	// ----------------------------------------------------------------
	localparam int SCG_COEF_W = 24;
	localparam int SCG_FRAC = 22; // Q1.22: 0x400000 is unity gain
	localparam int SCG_CNT_W = 5;
	localparam logic [4:0] SCG_LAST_BIT = 5'h17;
	localparam logic [23:0] SCG_COEF_RST = 24'h000000;
	localparam logic [23:0] SCG_ONE = 24'h400000;
	localparam logic [23:0] SCG_MINUS_ONE = 24'hc00000;
	localparam logic [23:0] SCG_MOST_NEG = 24'h800000;
	localparam logic [23:0] SCG_ZERO = 24'h000000;
	localparam logic [4:0] SCG_CNT_RST = 5'h00;
	localparam logic [4:0] SCG_CNT_ONE = 5'h01;

	// ----------------------------------------------------------------
	// Serial write state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCG_WR_IDLE = 2'b01,
		SCG_WR_SHIFT = 2'b10
	} scg_wr_e;
endpackage

// file: logic/scg_gain.sv
/*
 * Self-calibration gain coefficient register with its serial access
 * and the gain stage of the conversion result path.
 * Assumes one clock and asynchronous active-low reset from the core,
 * serial bits already framed by the command decoder, and a
 * calibration sequencer that flags busy and delivers measured gain.
 */
`timescale 1ns/1ps
module scg_gain
	import scg_pkg::*;
#(
	parameter int FRAC_BITS = SCG_FRAC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wr_start,
	input wire logic wr_bit_valid,
	input wire logic wr_bit,
	input wire logic rd_load,
	input wire logic rd_shift,
	output logic rd_bit,
	output logic wr_rejected,
	input wire logic cal_busy,
	input wire logic cal_done,
	input wire logic [23:0] cal_gain,
	input wire logic self_gain_bypass,
	input wire logic self_offset_bypass,
	input wire logic [23:0] self_offset_coefficient,
	input wire logic raw_valid,
	input wire logic [23:0] raw_result,
	output logic corr_valid,
	output logic [23:0] corr_result,
	output logic [23:0] self_gain_coefficient
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	scg_wr_e wr_state_q;
	logic [4:0] wr_cnt_q;
	logic [23:0] wr_sr_q;
	logic [23:0] wr_word;
	logic wr_commit;
	logic [23:0] coef_q;
	logic [23:0] rd_sr_q;
	logic rej_q;
	logic [23:0] off_q;
	logic off_v_q;
	logic [23:0] out_q;
	logic out_v_q;
	logic signed [24:0] diff;
	logic signed [47:0] prod;
	logic signed [47:0] prod_rnd;
	logic [23:0] scaled;

	// Clamp a 26-bit signed value into 24 bits
	function automatic logic [23:0] scg_sat(input logic [25:0] v);
		logic [23:0] r;
		r = v[23:0];
		if (v[25:23] != 3'b000 && v[25:23] != 3'b111) begin
			r = {v[25], {23{~v[25]}}};
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Serial write of the coefficient
	// ----------------------------------------------------------------
	// Word as it stands once the final bit arrives
	assign wr_word = {wr_sr_q[22:0], wr_bit};
	assign wr_commit = (wr_state_q == SCG_WR_SHIFT) && wr_bit_valid &&
		(wr_cnt_q == SCG_LAST_BIT);

	// Bit counter and shifter; a fresh start aborts a partial word
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_state_q <= SCG_WR_IDLE;
			wr_cnt_q <= SCG_CNT_RST;
			wr_sr_q <= SCG_ZERO;
		end else if (wr_start) begin
			wr_state_q <= SCG_WR_SHIFT;
			wr_cnt_q <= SCG_CNT_RST;
		end else begin
			unique case (wr_state_q)
				SCG_WR_IDLE: begin
					wr_cnt_q <= SCG_CNT_RST;
				end
				SCG_WR_SHIFT: begin
					if (wr_bit_valid) begin
						wr_sr_q <= wr_word;
						wr_cnt_q <= wr_cnt_q + SCG_CNT_ONE;
						if (wr_cnt_q == SCG_LAST_BIT) begin
							wr_state_q <= SCG_WR_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Coefficient register
	// ----------------------------------------------------------------
	// Calibration result beats a host word landing in the same cycle,
	// so the measured value is never lost
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			coef_q <= SCG_COEF_RST;
		end else if (cal_done) begin
			coef_q <= cal_gain;
		end else if (wr_commit && !cal_busy) begin
			coef_q <= wr_word;
		end
	end

	// One-cycle flag for a word thrown away during calibration
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rej_q <= 1'b0;
		end else begin
			rej_q <= wr_commit && (cal_busy || cal_done);
		end
	end

	// ----------------------------------------------------------------
	// Serial read of the coefficient
	// ----------------------------------------------------------------
	// Snapshot at load so a calibration mid-read cannot tear the word
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_sr_q <= SCG_ZERO;
		end else if (rd_load) begin
			rd_sr_q <= coef_q;
		end else if (rd_shift) begin
			rd_sr_q <= {rd_sr_q[22:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// Offset removal stage
	// ----------------------------------------------------------------
	assign diff = $signed({raw_result[23], raw_result}) -
		$signed({self_offset_coefficient[23], self_offset_coefficient});

	// Subtract first, so the gain sees an offset-free code
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			off_q <= SCG_ZERO;
			off_v_q <= 1'b0;
		end else begin
			off_v_q <= raw_valid;
			if (raw_valid) begin
				if (self_offset_bypass) begin
					off_q <= raw_result;
				end else begin
					off_q <= scg_sat({diff[24], diff});
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Gain stage
	// ----------------------------------------------------------------
	// Signed product, half-LSB rounding, then clamp; a full 48-bit
	// product costs area but removes any truncation bias
	assign prod = $signed(off_q) * $signed(coef_q);
	assign prod_rnd = prod + (48'sd1 <<< (FRAC_BITS - 1));
	assign scaled = scg_sat(26'(prod_rnd >>> FRAC_BITS));

	// Result leaves towards the system offset and gain stages
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= SCG_ZERO;
			out_v_q <= 1'b0;
		end else begin
			out_v_q <= off_v_q;
			if (off_v_q) begin
				out_q <= self_gain_bypass ? off_q : scaled;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rd_bit = rd_sr_q[23];
	assign wr_rejected = rej_q;
	assign corr_valid = out_v_q;
	assign corr_result = out_q;
	assign self_gain_coefficient = coef_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_wr_load;
		@(posedge clock) disable iff (!rst_n)
		wr_commit && !cal_busy && !cal_done |=>
			coef_q == $past(wr_word);
	endproperty
	a_wr_load: assert property (p_wr_load)
		else $error("host word not stored");

	property p_busy_hold;
		@(posedge clock) disable iff (!rst_n)
		cal_busy && !cal_done |=> $stable(coef_q);
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("coefficient changed while calibrating");

	property p_cal_load;
		@(posedge clock) disable iff (!rst_n)
		cal_done |=> coef_q == $past(cal_gain) && !corr_valid ||
			coef_q == $past(cal_gain);
	endproperty
	a_cal_load: assert property (p_cal_load)
		else $error("calibration gain not stored");

	property p_hold;
		@(posedge clock) disable iff (!rst_n)
		!cal_done && !wr_commit |=> $stable(coef_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("coefficient changed without cause");

	property p_rd_order;
		@(posedge clock) disable iff (!rst_n)
		rd_load ##1 (rd_shift && !rd_load) |=>
			rd_bit == $past(coef_q[22], 2);
	endproperty
	a_rd_order: assert property (p_rd_order)
		else $error("read bit order wrong");

	property p_rd_msb;
		@(posedge clock) disable iff (!rst_n)
		rd_load |=> rd_bit == $past(coef_q[23]);
	endproperty
	a_rd_msb: assert property (p_rd_msb)
		else $error("read does not start with held msb");

	property p_bypass;
		@(posedge clock) disable iff (!rst_n)
		off_v_q && self_gain_bypass |=> corr_result == $past(off_q);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass did not pass result through");

	property p_unity;
		@(posedge clock) disable iff (!rst_n)
		off_v_q && !self_gain_bypass && coef_q == SCG_ONE |=>
			corr_result == $past(off_q);
	endproperty
	a_unity: assert property (p_unity)
		else $error("unity gain changed the result");

	property p_negate;
		@(posedge clock) disable iff (!rst_n)
		off_v_q && !self_gain_bypass && coef_q == SCG_MINUS_ONE &&
			off_q != SCG_MOST_NEG |=>
			corr_result == 24'(-$signed($past(off_q)));
	endproperty
	a_negate: assert property (p_negate)
		else $error("negative gain not treated as signed");

	property p_latency;
		@(posedge clock) disable iff (!rst_n)
		raw_valid |-> ##2 corr_valid;
	endproperty
	a_latency: assert property (p_latency)
		else $error("result not delivered two cycles later");

	property p_off_first;
		@(posedge clock) disable iff (!rst_n)
		raw_valid && self_offset_bypass |=> off_q == $past(raw_result);
	endproperty
	a_off_first: assert property (p_off_first)
		else $error("offset bypass altered the raw result");

	// Only a finished word that met a running calibration is flagged
	property p_reject;
		@(posedge clock) disable iff (!rst_n)
		wr_commit |=> wr_rejected == $past(cal_busy || cal_done);
	endproperty
	a_reject: assert property (p_reject)
		else $error("dropped word flag wrong");

	c_cal: cover property (@(posedge clock) disable iff (!rst_n)
		cal_done);
	c_rejected: cover property (@(posedge clock) disable iff (!rst_n)
		wr_commit && cal_busy);
	c_scaled: cover property (@(posedge clock) disable iff (!rst_n)
		off_v_q && !self_gain_bypass ##1 corr_valid);
	c_bypass: cover property (@(posedge clock) disable iff (!rst_n)
		off_v_q && self_gain_bypass);
endmodule

// file: sim/scg_host.sv
/*
 * Host controller model for the coefficient's serial access.
 * Assumes the bench calls its tasks and that the block under test
 * samples every strobe on the rising clock edge.
 */
`timescale 1ns/1ps
module scg_host (
	input wire logic clock,
	input wire logic rd_bit,
	output logic wr_start,
	output logic wr_bit_valid,
	output logic wr_bit,
	output logic rd_load,
	output logic rd_shift
);
	// ------------------------------------------------------------
	// Serial transfers
	// ------------------------------------------------------------
	// Idle levels at time zero
	initial begin
		wr_start = 1'b0;
		wr_bit_valid = 1'b0;
		wr_bit = 1'b0;
		rd_load = 1'b0;
		rd_shift = 1'b0;
	end

	// Whole word, top bit first; data line flips once unqualified
	task automatic put(input logic [23:0] v);
		@(posedge clock) wr_start <= 1'b1;
		for (int i = 23; i >= 0; i--) begin
			@(posedge clock) wr_start <= 1'b0;
			wr_bit_valid <= 1'b1;
			wr_bit <= v[i];
		end
		@(posedge clock) wr_bit_valid <= 1'b0;
		wr_bit <= ~v[0];
	endtask

	// Snapshot, then one shift per bit after the first; sampled once settled
	task automatic get(output logic [23:0] v);
		@(posedge clock) rd_load <= 1'b1;
		for (int i = 23; i >= 0; i--) begin
			@(posedge clock) rd_load <= 1'b0;
			rd_shift <= (i != 0);
			#1 v[i] = rd_bit;
		end
	endtask
endmodule

// file: sim/scg_gain_test.sv
/*
 * Self-checking bench for the gain coefficient block.
 * Assumes the host model drives the serial side; the bench drives
 * calibration and the result path with fixed expected values.
 */
`timescale 1ns/1ps
module scg_gain_test;
	import scg_pkg::*;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic wr_start, wr_bit_valid, wr_bit, rd_load, rd_shift, rd_bit;
	logic wr_rejected, corr_valid, rej_seen = 1'b0;
	logic cal_busy = 1'b0, cal_done = 1'b0, raw_valid = 1'b0;
	logic self_gain_bypass = 1'b0, self_offset_bypass = 1'b0;
	logic [23:0] cal_gain = 24'h000000, raw_result = 24'h000000;
	logic [23:0] self_offset_coefficient = 24'h000000;
	logic [23:0] corr_result, self_gain_coefficient, v;
	int num_errors = 0;
	int samples_checked = 0;

	scg_gain uut (.clock(clock), .rst_n(rst_n), .wr_start(wr_start),
		.wr_bit_valid(wr_bit_valid), .wr_bit(wr_bit), .rd_load(rd_load),
		.rd_shift(rd_shift), .rd_bit(rd_bit), .wr_rejected(wr_rejected),
		.cal_busy(cal_busy), .cal_done(cal_done), .cal_gain(cal_gain),
		.self_gain_bypass(self_gain_bypass),
		.self_offset_bypass(self_offset_bypass),
		.self_offset_coefficient(self_offset_coefficient),
		.raw_valid(raw_valid), .raw_result(raw_result),
		.corr_valid(corr_valid), .corr_result(corr_result),
		.self_gain_coefficient(self_gain_coefficient));
	scg_host host (.clock(clock), .rd_bit(rd_bit), .wr_start(wr_start),
		.wr_bit_valid(wr_bit_valid), .wr_bit(wr_bit), .rd_load(rd_load),
		.rd_shift(rd_shift));

	// 200 MHz clock
	initial begin
		forever #2.5 clock = ~clock;
	end

	// Dropped words pulse for one cycle only, so latch them
	always @(posedge clock) begin
		if (wr_rejected === 1'b1) rej_seen <= 1'b1;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic finish_test;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [23:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask

	// One conversion; waits a bounded time for the result
	task automatic conv(input logic [23:0] r, o, e);
		@(posedge clock) raw_valid <= 1'b1;
		raw_result <= r;
		self_offset_coefficient <= o;
		@(posedge clock) raw_valid <= 1'b0;
		for (int n = 0; n < 8; n++) begin
			#1 if (corr_valid === 1'b1) break;
			@(posedge clock);
		end
		if (corr_valid !== 1'b1) begin
			num_errors++;
			$display("MISMATCH %0t no result", $time);
			finish_test();
		end else begin
			check(corr_result, e);
		end
	endtask

	task automatic wr_conv(input logic [23:0] c, r, o, e);
		host.put(c);
		conv(r, o, e);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		#1 check(self_gain_coefficient, SCG_COEF_RST);
		conv(24'h001000, 24'h000000, 24'h000000);
		host.put(24'h5a3c96);
		@(posedge clock);
		#1 check(self_gain_coefficient, 24'h5a3c96);
		host.get(v);
		check(v, 24'h5a3c96);
		wr_conv(24'h600000, 24'h001000, 24'h000100, 24'h001680);
		// Gain of 1.5 held, so a skipped stage shows in the result
		@(posedge clock) self_gain_bypass <= 1'b1;
		conv(24'h001000, 24'h000100, 24'h000f00);
		@(posedge clock) self_gain_bypass <= 1'b0;
		self_offset_bypass <= 1'b1;
		conv(24'h001000, 24'h000100, 24'h001800);
		@(posedge clock) self_offset_bypass <= 1'b0;
		wr_conv(24'hc00000, 24'h000200, 24'h000000, 24'hfffe00);
		wr_conv(24'h7fffff, 24'h100000, 24'h000000, 24'h200000);
		wr_conv(24'h400001, 24'h000003, 24'h000000, 24'h000003);
		check(self_gain_coefficient, 24'h400001);
		// Calibration result replaces the host word
		@(posedge clock) cal_gain <= 24'h222222;
		cal_done <= 1'b1;
		@(posedge clock) cal_done <= 1'b0;
		@(posedge clock);
		#1 check(self_gain_coefficient, 24'h222222);
		host.get(v);
		check(v, 24'h222222);
		check({23'h0, rej_seen}, 24'h000000);
		// Host word during calibration must be dropped
		@(posedge clock) cal_busy <= 1'b1;
		host.put(24'h333333);
		repeat (2) @(posedge clock);
		#1 check(self_gain_coefficient, 24'h222222);
		check({23'h0, rej_seen}, 24'h000001);
		@(posedge clock) cal_busy <= 1'b0;
		finish_test();
	end
endmodule
